// ===== rtl/scs_clock_select.sv
// Behaviour
// - switching disabled: every reset takes source from configuration bits.
// - switching enabled: power-on/brown-out use config; others keep current.
// - read-only current source field at bits 14:12, eight encodings.
// - writable requested source field at bits 10:8, same encodings.
// - requested field reloads from configuration selection at reset.
// - lock status reads 0 during a switch and for non-PLL modes.
// - drive-level bit ignored when secondary takes a digital clock.
// - bits 15 and 11 read zero; writes to them ignored.
// - oscillator-failure trap flag at bit 1 of interrupt control one.
// - control register governs switching and reports clock status.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select
    import scs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [2:0] reset_kind,
    input wire logic switching_enabled,
    input wire logic [2:0] config_source_sel,
    input wire logic secondary_input_kind,
    input wire logic pll_locked_raw,
    input wire logic clock_fail_raw,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    output logic [2:0] active_source,
    output logic switch_busy,
    output logic secondary_osc_enable,
    output logic secondary_drive_level,
    output logic osc_failure_trap_flag,
    output logic irq
);
    logic [2:0] current_source_sel_ff;
    logic [2:0] requested_source_sel_ff;
    logic switch_request_ff;
    logic switch_lockout_ff;
    logic clock_fail_flag_ff;
    logic sec_drive_ff;
    logic sec_enable_ff;
    logic nesting_disable_ff;
    logic osc_trap_ff;
    logic [SETTLE_W-1:0] settle_ff;
    logic [IRQ_WIDTH-1:0] irq_status_ff;
    logic [IRQ_WIDTH-1:0] irq_mask_ff;
    logic [15:0] rdata_ff;
    logic [2:0] active_ff;
    logic busy_ff;
    logic drive_out_ff;
    logic enable_out_ff;
    logic trap_out_ff;
    logic irq_ff;
    logic init_pending_ff;
    logic [1:0] raw_sync;
    logic pll_locked;
    logic clock_fail;
    logic clock_fail_d_ff;
    logic pll_locked_d_ff;
    logic lock_status;
    logic switch_done;
    logic fail_rise;
    logic lock_rise;
    logic wr_osc;
    logic wr_int;
    logic [2:0] reset_source;
    logic [IRQ_WIDTH-1:0] irq_events;

    scs_sync #(.WIDTH(2)) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in({clock_fail_raw, pll_locked_raw}),
        .sync_out(raw_sync)
    );
    assign pll_locked = raw_sync[0];
    assign clock_fail = raw_sync[1];

    assign wr_osc = reg_write && (reg_addr == ADDR_OSC_CONTROL);
    assign wr_int = reg_write && (reg_addr == ADDR_INT_CONTROL_ONE);
    assign switch_done = switch_request_ff && (settle_ff == '0) &&
        !init_pending_ff;
    assign fail_rise = clock_fail && !clock_fail_d_ff;
    assign lock_rise = lock_status && !pll_locked_d_ff;

    // lock forced low while switching or in a non-PLL mode
    assign lock_status = pll_locked && !switch_request_ff &&
        scs_uses_pll(current_source_sel_ff);

    // source chosen after a reset
    always_comb begin
        if (!switching_enabled) begin
            reset_source = config_source_sel;
        end else begin
            case (reset_kind)
                RST_POWER_ON: reset_source = config_source_sel;
                RST_BROWNOUT: reset_source = config_source_sel;
                default: reset_source = current_source_sel_ff;
            endcase
        end
    end

    // straps are caught in the first cycle after release
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            init_pending_ff <= 1'b1;
        end else begin
            init_pending_ff <= 1'b0;
        end
    end

    // current source: hardware maintained, read only
    always_ff @(posedge clk_sys) begin
        if (init_pending_ff && !reset) begin
            current_source_sel_ff <= reset_source;
        end else if (switch_done) begin
            current_source_sel_ff <= requested_source_sel_ff;
        end
    end

    // requested source
    always_ff @(posedge clk_sys) begin
        if (init_pending_ff && !reset) begin
            requested_source_sel_ff <= config_source_sel;
        end else if (wr_osc && !switch_request_ff && !switch_lockout_ff) begin
            requested_source_sel_ff <= reg_wdata[REQ_SEL_LSB +: 3];
        end
    end

    // switch request and settle count
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            switch_request_ff <= 1'b0;
            settle_ff <= '0;
        end else if (switch_done) begin
            switch_request_ff <= 1'b0;
        end else if (switch_request_ff) begin
            settle_ff <= settle_ff - 1'b1;
        end else if (wr_osc && reg_wdata[SWITCH_REQ_BIT] &&
                     switching_enabled && !switch_lockout_ff) begin
            switch_request_ff <= 1'b1;
            settle_ff <= SETTLE_W'(SWITCH_SETTLE_CYC - 1);
        end
    end

    // lockout is set-only; fail flag clears only by writing zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            switch_lockout_ff <= 1'b0;
            clock_fail_flag_ff <= 1'b0;
            sec_drive_ff <= 1'b0;
            sec_enable_ff <= 1'b0;
        end else begin
            if (wr_osc && reg_wdata[LOCKOUT_BIT]) begin
                switch_lockout_ff <= 1'b1;
            end
            if (clock_fail) begin
                clock_fail_flag_ff <= 1'b1;
            end else if (wr_osc && !reg_wdata[FAIL_FLAG_BIT]) begin
                clock_fail_flag_ff <= 1'b0;
            end
            if (wr_osc) begin
                sec_drive_ff <= reg_wdata[SEC_DRIVE_BIT];
                sec_enable_ff <= reg_wdata[SEC_ENABLE_BIT];
            end
        end
    end

    // interrupt control one
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            nesting_disable_ff <= 1'b0;
            osc_trap_ff <= 1'b0;
        end else begin
            if (wr_int) begin
                nesting_disable_ff <= reg_wdata[NEST_DIS_BIT];
            end
            if (fail_rise) begin
                osc_trap_ff <= 1'b1;
            end else if (wr_int) begin
                osc_trap_ff <= reg_wdata[OSC_TRAP_BIT];
            end
        end
    end

    // edge detect history
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            clock_fail_d_ff <= 1'b0;
            pll_locked_d_ff <= 1'b0;
        end else begin
            clock_fail_d_ff <= clock_fail;
            pll_locked_d_ff <= lock_status;
        end
    end

    // sticky interrupt status, write one to clear; set wins
    always_comb begin
        irq_events = '0;
        irq_events[IRQ_SWITCH_DONE] = switch_done;
        irq_events[IRQ_CLOCK_FAIL] = fail_rise;
        irq_events[IRQ_PLL_LOCK] = lock_rise;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_status_ff <= '0;
            irq_mask_ff <= IRQ_MASK_RESET;
        end else begin
            if (reg_write && reg_addr == ADDR_IRQ_MASK) begin
                irq_mask_ff <= reg_wdata[IRQ_WIDTH-1:0];
            end
            if (reg_write && reg_addr == ADDR_IRQ_STATUS) begin
                irq_status_ff <= (irq_status_ff &
                    ~reg_wdata[IRQ_WIDTH-1:0]) | irq_events;
            end else begin
                irq_status_ff <= irq_status_ff | irq_events;
            end
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_ff <= READ_ZERO;
        end else if (reg_read) begin
            rdata_ff <= READ_ZERO;
            case (reg_addr)
                ADDR_OSC_CONTROL: begin
                    rdata_ff[CUR_SEL_LSB +: 3] <= current_source_sel_ff;
                    rdata_ff[REQ_SEL_LSB +: 3] <= requested_source_sel_ff;
                    rdata_ff[LOCKOUT_BIT] <= switch_lockout_ff;
                    rdata_ff[PLL_LOCK_BIT] <= lock_status;
                    rdata_ff[FAIL_FLAG_BIT] <= clock_fail_flag_ff;
                    rdata_ff[SEC_DRIVE_BIT] <= sec_drive_ff;
                    rdata_ff[SEC_ENABLE_BIT] <= sec_enable_ff;
                    rdata_ff[SWITCH_REQ_BIT] <= switch_request_ff;
                end
                ADDR_INT_CONTROL_ONE: begin
                    rdata_ff[NEST_DIS_BIT] <= nesting_disable_ff;
                    rdata_ff[OSC_TRAP_BIT] <= osc_trap_ff;
                end
                ADDR_IRQ_STATUS: rdata_ff[IRQ_WIDTH-1:0] <= irq_status_ff;
                ADDR_IRQ_MASK: rdata_ff[IRQ_WIDTH-1:0] <= irq_mask_ff;
                default: rdata_ff <= READ_ZERO;
            endcase
        end else begin
            rdata_ff <= READ_ZERO;
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            active_ff <= 3'h0;
            busy_ff <= 1'b0;
            drive_out_ff <= 1'b0;
            enable_out_ff <= 1'b0;
            trap_out_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            active_ff <= current_source_sel_ff;
            busy_ff <= switch_request_ff;
            // drive level meaningless with a digital clock input
            drive_out_ff <= sec_drive_ff && secondary_input_kind;
            enable_out_ff <= sec_enable_ff;
            trap_out_ff <= osc_trap_ff;
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    assign reg_rdata = rdata_ff;
    assign active_source = active_ff;
    assign switch_busy = busy_ff;
    assign secondary_osc_enable = enable_out_ff;
    assign secondary_drive_level = drive_out_ff;
    assign osc_failure_trap_flag = trap_out_ff;
    assign irq = irq_ff;
endmodule
`default_nettype wire

// ===== include/scs_pkg.sv
package scs_pkg;
    // register addresses (byte addresses on the plain port)
    localparam logic [3:0] ADDR_OSC_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_INT_CONTROL_ONE = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
    localparam logic [3:0] ADDR_CONFIG_VIEW = 4'h0;
    // oscillator_control field positions
    localparam int CUR_SEL_LSB = 12;
    localparam int REQ_SEL_LSB = 8;
    localparam int LOCKOUT_BIT = 7;
    localparam int PLL_LOCK_BIT = 5;
    localparam int FAIL_FLAG_BIT = 3;
    localparam int SEC_DRIVE_BIT = 2;
    localparam int SEC_ENABLE_BIT = 1;
    localparam int SWITCH_REQ_BIT = 0;
    // interrupt_control_one field positions
    localparam int NEST_DIS_BIT = 15;
    localparam int OSC_TRAP_BIT = 1;
    // irq status bits
    localparam int IRQ_SWITCH_DONE = 0;
    localparam int IRQ_CLOCK_FAIL = 1;
    localparam int IRQ_PLL_LOCK = 2;
    localparam int IRQ_WIDTH = 3;
    // reset values
    localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    // switch settle time: 1000 ns at 8 ns
    localparam int SWITCH_SETTLE_NS = 1000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SWITCH_SETTLE_CYC = SWITCH_SETTLE_NS / CLK_PERIOD_NS;
    localparam int SETTLE_W = 8;

    typedef enum logic [2:0] {
        SRC_FAST_RC = 3'h0,
        SRC_FAST_RC_MULT = 3'h1,
        SRC_PRIMARY = 3'h2,
        SRC_PRIMARY_MULT = 3'h3,
        SRC_SECONDARY = 3'h4,
        SRC_LOWPOWER_RC = 3'h5,
        SRC_LOWPOWER_FAST_RC_DIV = 3'h6,
        SRC_FAST_RC_DIV = 3'h7
    } scs_source_type;

    typedef enum logic [2:0] {
        RST_POWER_ON,
        RST_BROWNOUT,
        RST_PIN,
        RST_WATCHDOG,
        RST_SOFTWARE
    } scs_reset_kind_type;

    function automatic logic scs_uses_pll(input logic [2:0] sel);
        return (sel == SRC_FAST_RC_MULT) || (sel == SRC_PRIMARY_MULT);
    endfunction
endpackage

// ===== rtl/scs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module scs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one_ff;
    logic [WIDTH-1:0] stage_two_ff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage_one_ff <= '0;
            stage_two_ff <= '0;
        end else begin
            stage_one_ff <= async_in;
            stage_two_ff <= stage_one_ff;
        end
    end

    assign sync_out = stage_two_ff;
endmodule
`default_nettype wire

// ===== tb/scs_clock_select_checker.sv
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select_checker
    import scs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic secondary_input_kind,
    input wire logic clock_fail_raw,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic [2:0] active_source,
    input wire logic switch_busy,
    input wire logic secondary_osc_enable,
    input wire logic secondary_drive_level,
    input wire logic osc_failure_trap_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [7:0] busy_cnt_ff;
    always_ff @(posedge clk_sys) begin
        if (reset || !switch_busy) begin
            busy_cnt_ff <= 8'h00;
        end else begin
            busy_cnt_ff <= busy_cnt_ff + 8'h01;
        end
    end
    sequence s_osc_read;
        reg_read && reg_addr == ADDR_OSC_CONTROL;
    endsequence
    sequence s_osc_write;
        reg_write && reg_addr == ADDR_OSC_CONTROL;
    endsequence
    property p_rdata_idle;
        !reg_read |=> reg_rdata == 16'h0000;
    endproperty
    property p_unimpl;
        s_osc_read |=> (reg_rdata & 16'h8850) == 16'h0000;
    endproperty
    property p_cur_view;
        s_osc_read |=> reg_rdata[14:12] == active_source;
    endproperty
    property p_lock;
        s_osc_read |=> !reg_rdata[5] ||
            (reg_rdata[12] && !reg_rdata[14] && !reg_rdata[0]);
    endproperty
    property p_drive;
        !secondary_input_kind |=> !secondary_drive_level;
    endproperty
    property p_switch_len;
        !$past(reset) && $fell(switch_busy) |->
            busy_cnt_ff inside {[8'h7c:8'h7e]};
    endproperty
    property p_active_hold;
        switch_busy ##1 switch_busy |-> $stable(active_source);
    endproperty
    property p_trap;
        $rose(clock_fail_raw) |-> ##[1:6] osc_failure_trap_flag;
    endproperty
    property p_enable;
        s_osc_write ##2 1'b1 |->
            secondary_osc_enable == $past(reg_wdata[SEC_ENABLE_BIT], 2);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not idle");
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented bits not zero");
    a_cur_view: assert property (p_cur_view)
        else $error("current field differs from active source");
    a_lock: assert property (p_lock)
        else $error("lock shown while switching or without pll");
    a_drive: assert property (p_drive)
        else $error("drive level active with digital input");
    a_switch_len: assert property (p_switch_len)
        else $error("switch length wrong");
    a_active_hold: assert property (p_active_hold)
        else $error("active source moved during switch");
    a_trap: assert property (p_trap)
        else $error("trap flag not set after failure");
    a_enable: assert property (p_enable)
        else $error("secondary enable does not follow write");
endmodule
bind scs_clock_select scs_clock_select_checker u_checker (
    .clk_sys(clk_sys), .reset(reset),
    .secondary_input_kind(secondary_input_kind),
    .clock_fail_raw(clock_fail_raw), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .active_source(active_source),
    .switch_busy(switch_busy), .secondary_osc_enable(secondary_osc_enable),
    .secondary_drive_level(secondary_drive_level),
    .osc_failure_trap_flag(osc_failure_trap_flag)
);
`default_nettype wire

// ===== tb/scs_clock_select_test.sv
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select_test
    import scs_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [2:0] reset_kind = 3'h0;
    logic switching_enabled = 1'b1;
    logic [2:0] config_source_sel = 3'h0;
    logic secondary_input_kind = 1'b0;
    logic pll_locked_raw = 1'b0;
    logic clock_fail_raw = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata, d;
    logic [2:0] active_source;
    logic switch_busy, secondary_osc_enable, secondary_drive_level;
    logic osc_failure_trap_flag, irq;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    // nibbles: reset kind, switching enabled, config code, expected current
    logic [15:0] rows [8] = '{16'h0133, 16'h2153, 16'h3066, 16'h4116,
        16'h1144, 16'h2000, 16'h4077, 16'h3127};

    scs_clock_select dut (
        .clk_sys(clk_sys), .reset(reset), .reset_kind(reset_kind),
        .switching_enabled(switching_enabled),
        .config_source_sel(config_source_sel),
        .secondary_input_kind(secondary_input_kind),
        .pll_locked_raw(pll_locked_raw), .clock_fail_raw(clock_fail_raw),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .active_source(active_source), .switch_busy(switch_busy),
        .secondary_osc_enable(secondary_osc_enable),
        .secondary_drive_level(secondary_drive_level),
        .osc_failure_trap_flag(osc_failure_trap_flag), .irq(irq)
    );

    always #4 clk_sys = ~clk_sys;

    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [15:0] seen,
            input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] w);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic do_reset(input logic [15:0] r);
        @(posedge clk_sys);
        reset <= 1'b1;
        reset_kind <= r[14:12];
        switching_enabled <= r[8];
        config_source_sel <= r[6:4];
        repeat (5) @(posedge clk_sys);
        #1;
        check("reset outs", {irq, switch_busy, osc_failure_trap_flag,
            secondary_drive_level, active_source, reg_rdata[8:0]},
            16'h0000);
        @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    initial begin
        for (int i = 0; i < 8; i++) begin
            do_reset(rows[i]);
            rd(ADDR_OSC_CONTROL);
            check("osc ctl", d, {1'b0, rows[i][2:0], 1'b0, rows[i][6:4],
                8'h00});
            check("active", {13'h0000, active_source},
                {13'h0000, rows[i][2:0]});
        end
        @(posedge clk_sys);
        pll_locked_raw <= 1'b1;
        wr(ADDR_OSC_CONTROL, 16'h0101);
        rd(ADDR_OSC_CONTROL);
        check("switching", d & 16'h0721, 16'h0101);
        wr(ADDR_OSC_CONTROL, 16'h0501);
        for (int k = 0; k < 200 && switch_busy === 1'b1; k++) begin
            @(posedge clk_sys);
        end
        settle();
        rd(ADDR_OSC_CONTROL);
        check("switched", d, 16'h1120);
        check("masked", {12'h000, active_source, irq}, 16'h0002);
        wr(ADDR_IRQ_MASK, 16'h0001);
        settle();
        check("irq on", {15'h0000, irq}, 16'h0001);
        wr(ADDR_IRQ_STATUS, 16'h0007);
        settle();
        check("irq off", {15'h0000, irq}, 16'h0000);
        wr(ADDR_OSC_CONTROL, 16'h0106);
        settle();
        check("digital", {14'h0000, secondary_osc_enable,
            secondary_drive_level}, 16'h0002);
        @(posedge clk_sys);
        secondary_input_kind <= 1'b1;
        clock_fail_raw <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        check("crystal", {14'h0000, secondary_osc_enable,
            secondary_drive_level}, 16'h0003);
        check("trap pin", {15'h0000, osc_failure_trap_flag}, 16'h0001);
        rd(ADDR_INT_CONTROL_ONE);
        check("trap reg", d, 16'h0002);
        wr(ADDR_OSC_CONTROL, 16'hf8f0);
        wr(ADDR_OSC_CONTROL, 16'h0701);
        rd(ADDR_OSC_CONTROL);
        check("lockout", d, 16'h10a8);
        check("no switch", {15'h0000, switch_busy}, 16'h0000);
        rd(4'h2);
        check("unmapped", d, 16'h0000);
        finish_test();
    end
endmodule
`default_nettype wire
